/* rtl/sro_cfg.svh */
// Constants for the serial receiver output control block
`ifndef SRO_CFG_SVH
`define SRO_CFG_SVH

// Register bus geometry
`define SRO_ADDR_W        4
`define SRO_DATA_W        32

// Register offsets (byte addresses)
`define SRO_REG_STATUS    4'h0
`define SRO_REG_MASK      4'h4
`define SRO_REG_LIVE      4'h8

// Event bit positions in status and mask
`define SRO_EV_W          3
`define SRO_EV_LOCK_GAIN  0
`define SRO_EV_LOCK_LOSS  1
`define SRO_EV_SLEEP      2

// Synchronised pin bit positions
`define SRO_PIN_W         4
`define SRO_PIN_LOCK      0
`define SRO_PIN_SLEEP_N   1
`define SRO_PIN_OE        2
`define SRO_PIN_EDGE      3

// Reset values
`define SRO_PIN_RST       4'h2
`define SRO_MASK_RST      3'h0
`define SRO_STATUS_RST    3'h0

// Parallel word width
`define SRO_WORD_W        10

`endif

/* rtl/sro_out_ctrl.sv */
// Output, lock indicator and sleep control of the deserializer
`timescale 1ns/1ps
`include "sro_cfg.svh"

// Functional notes
// - Data aligned to selected recovered clock edge
// - Sleep stops PLL, floats all outputs
// - Lock indicator low when locked, else high
// - Recovered clock runs at word rate
// - Enable low floats data and clock
// - Lock indicator driven whenever awake
// - Clock and data active only when locked
// - Lock high floats data and clock
module sro_out_ctrl (
	input  wire logic                    i_mclk,
	input  wire logic                    i_rst,
	input  wire logic                    i_pll_lock,
	input  wire logic [`SRO_WORD_W-1:0]  i_word,
	input  wire logic                    i_word_stb,
	input  wire logic                    i_sleep_control_n,
	input  wire logic                    i_out_enable,
	input  wire logic                    i_clk_edge_sel,
	input  wire logic [`SRO_ADDR_W-1:0]  i_addr,
	input  wire logic [`SRO_DATA_W-1:0]  i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	output logic      [`SRO_DATA_W-1:0]  o_rdata,
	output logic                         o_irq,
	output logic      [`SRO_WORD_W-1:0]  o_parallel_data_out,
	output logic                         o_parallel_data_out_oe,
	output logic                         o_rclk,
	output logic                         o_rclk_oe,
	output logic                         o_lock_n,
	output logic                         o_lock_oe,
	output logic                         o_pll_run
);
	logic [`SRO_PIN_W-1:0]  pins;        // Filtered pin levels
	logic                   lock_s;      // PLL lock, synchronised
	logic                   awake_s;     // Sleep control high
	logic                   oe_s;        // Output enable pin
	logic                   edge_s;      // Edge select pin
	sro_pkg::sro_state_t    state_q;     // Link state
	sro_pkg::sro_state_t    next_state;     // Link state for the next cycle
	logic                   next_active;    // Data and clock driven next
	logic [`SRO_WORD_W-1:0] next_data;      // Parallel word for the next cycle
	logic                   next_rclk;      // Recovered clock level next
	logic                   next_lock_n;    // Lock indicator level next
	logic                   next_awake;     // PLL running and lock driven next
	logic [`SRO_EV_W-1:0]   ev;             // Event pulses to the registers
	logic [1:0]             lock_wait;      // Cycles unlocked with lock filtered
	logic [1:0]             next_lock_wait; // Next value of the lock wait count

	// Bundle towards the status, mask and live registers
	sro_regs_if regs_bus ();

	// All pins arrive from outside the clock domain
	sro_pin_sync #(
		.W       (`SRO_PIN_W),
		.RST_VAL (`SRO_PIN_RST)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_pin   ({i_clk_edge_sel, i_out_enable, i_sleep_control_n, i_pll_lock}),
		.o_level (pins)
	);

	assign lock_s  = pins[`SRO_PIN_LOCK];
	assign awake_s = pins[`SRO_PIN_SLEEP_N];
	assign oe_s    = pins[`SRO_PIN_OE];
	assign edge_s  = pins[`SRO_PIN_EDGE];

	// True when the state drives the lock indicator low
	function automatic logic is_locked(input sro_pkg::sro_state_t st);
		// Only the locked state counts; acquire and sleep do not
		return (st == sro_pkg::SRO_ST_LOCKED);
	endfunction

	// True when the state has the PLL stopped and the pins floating
	function automatic logic is_asleep(input sro_pkg::sro_state_t st);
		// Sleep is the only state with the PLL stopped
		return (st == sro_pkg::SRO_ST_SLEEP);
	endfunction

	// True on the cycle a decoded state flag switches on
	function automatic logic entered(input logic prev, input logic curr);
		// Rising edge of the flag from this cycle to the next
		return !prev && curr;
	endfunction

	// Link state transitions
	always_comb begin
		next_state = state_q;
		case (state_q)
			sro_pkg::SRO_ST_SLEEP: begin
				// Leave sleep to re-acquire lock
				if (awake_s) begin
					next_state = sro_pkg::SRO_ST_ACQUIRE;
				end
			end
			sro_pkg::SRO_ST_ACQUIRE: begin
				// Wait for filtered lock; sleep always wins
				if (!awake_s) begin
					next_state = sro_pkg::SRO_ST_SLEEP;
				end else if (lock_s) begin
					next_state = sro_pkg::SRO_ST_LOCKED;
				end
			end
			sro_pkg::SRO_ST_LOCKED: begin
				// Stay while awake and still locked
				if (!awake_s) begin
					next_state = sro_pkg::SRO_ST_SLEEP;
				end else if (!lock_s) begin
					next_state = sro_pkg::SRO_ST_ACQUIRE;
				end
			end
			default: begin
				// Unused code falls back to acquire, lock high
				next_state = sro_pkg::SRO_ST_ACQUIRE;
			end
		endcase
	end

	// Output values follow the next state so all change together
	always_comb begin
		// PLL and lock indicator are live in every state but sleep
		next_awake  = !is_asleep(next_state);
		// Lock indicator high unless locked, power-up included
		next_lock_n = !is_locked(next_state);
		// Data and clock only while locked and enabled
		next_active = !next_lock_n && oe_s;
		next_data   = o_parallel_data_out;
		next_rclk   = 1'b0;
		if (next_active) begin
			if (i_word_stb) begin
				// Launch phase: new word, clock at the inactive level
				next_data = i_word;
				next_rclk = !edge_s;
			end else begin
				// Strobe phase: the selected edge lands on stable data
				next_rclk = edge_s;
			end
		end else begin
			next_data = '0;
		end
	end

	// Event pulses for the status register
	always_comb begin
		ev = '0;
		ev[`SRO_EV_LOCK_GAIN] = entered(is_locked(state_q), is_locked(next_state));
		ev[`SRO_EV_LOCK_LOSS] = entered(!is_locked(state_q), !is_locked(next_state));
		ev[`SRO_EV_SLEEP]     = entered(is_asleep(state_q), is_asleep(next_state));
	end

	// State and output registers
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			// Power-up: acquire, lock high, data and clock floating
			state_q                <= sro_pkg::SRO_ST_ACQUIRE;
			o_parallel_data_out    <= '0;
			o_parallel_data_out_oe <= 1'b0;
			o_rclk                 <= 1'b0;
			o_rclk_oe              <= 1'b0;
			o_lock_n               <= 1'b1;
			o_lock_oe              <= 1'b1;
			o_pll_run              <= 1'b1;
		end else begin
			// Every output is a flip-flop fed by the next values
			state_q                <= next_state;
			o_parallel_data_out    <= next_data;
			o_parallel_data_out_oe <= next_active;
			o_rclk                 <= next_rclk;
			o_rclk_oe              <= next_active;
			o_lock_n               <= next_lock_n;
			o_lock_oe              <= next_awake;
			o_pll_run              <= next_awake;
		end
	end

	// Register file hookup
	assign regs_bus.addr  = i_addr;
	assign regs_bus.wdata = i_wdata;
	assign regs_bus.wr    = i_wr;
	assign regs_bus.rd    = i_rd;
	assign regs_bus.ev    = ev;
	assign regs_bus.live  = {edge_s, oe_s, !next_awake, !o_lock_n};

	sro_regs u_regs (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.bus    (regs_bus)
	);

	// Read data and interrupt come straight from register file flops
	assign o_rdata = regs_bus.rdata;
	assign o_irq   = regs_bus.irq;

	// Cycles spent unlocked while the filtered lock already stands
	always_comb begin
		if (awake_s && lock_s && o_lock_n) begin
			// Saturate so the count never wraps back to zero
			next_lock_wait = (lock_wait == 2'h3) ? 2'h3 : lock_wait + 2'h1;
		end else begin
			// Locked, asleep or no lock seen: start over
			next_lock_wait = 2'h0;
		end
	end

	// Register the lock wait count
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			lock_wait <= 2'h0;
		end else begin
			lock_wait <= next_lock_wait;
		end
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	// Word launched in rising-edge mode
	sequence s_launch;
		i_word_stb && next_active && edge_s;
	endsequence
	// Following cycle with no new word
	sequence s_hold;
		!i_word_stb && next_active && edge_s;
	endsequence
	// Word launched in falling-edge mode
	sequence s_launch_fall;
		i_word_stb && next_active && !edge_s;
	endsequence
	// Following cycle with no new word, falling-edge mode
	sequence s_hold_fall;
		!i_word_stb && next_active && !edge_s;
	endsequence
	// Lock filtered while unlocked, awake and enabled
	sequence s_gain;
		awake_s && oe_s && lock_s && o_lock_n;
	endsequence
	// Lock filtered, awake and enabled still a cycle later
	sequence s_kept;
		awake_s && oe_s && lock_s;
	endsequence

	// Sleep floats every output and stops the PLL
	sleep_float_a: assert property (!awake_s |=> !o_pll_run && !o_lock_oe && !o_rclk_oe && !o_parallel_data_out_oe)
		else $error("sleep did not float outputs");

	// Filtered lock pulls the indicator low on the next edge
	lock_level_a: assert property (o_lock_oe && awake_s && lock_s |=> !o_lock_n)
		else $error("lock indicator not low after lock");

	// Enable low floats data and clock, lock stays driven
	oe_float_a: assert property (awake_s && !oe_s |=> !o_parallel_data_out_oe && !o_rclk_oe && o_lock_oe)
		else $error("enable low did not float data and clock");

	// Unlocked: data and clock float, word parked at zero
	lock_float_a: assert property (o_lock_n
		|-> !o_parallel_data_out_oe && !o_rclk_oe && o_parallel_data_out == '0)
		else $error("outputs driven while unlocked");

	// Lock loss raises the indicator and floats the clock
	loss_float_a: assert property (state_q == sro_pkg::SRO_ST_LOCKED && awake_s && !lock_s
		|=> o_lock_n && o_lock_oe && !o_rclk_oe)
		else $error("lock loss not handled");

	// Rising-edge mode: clock rises onto a settled word
	rise_edge_a: assert property (s_launch ##1 s_hold |=> o_rclk && !$past(o_rclk))
		else $error("rising edge not after data launch");

	// Falling-edge mode: clock falls onto a settled word
	fall_edge_a: assert property (s_launch_fall ##1 s_hold_fall |=> !o_rclk && $past(o_rclk))
		else $error("falling edge not after data launch");

	// Strobed word appears on the next edge
	data_load_a: assert property (i_word_stb && next_active
		|=> o_parallel_data_out == $past(i_word) && o_parallel_data_out_oe)
		else $error("word not presented");

	// Word holds still between strobes
	data_hold_a: assert property (next_active && !i_word_stb |=> $stable(o_parallel_data_out))
		else $error("word changed without a strobe");

	// Clock parks at the selected edge level until the next word
	rclk_level_a: assert property (next_active && !i_word_stb |=> o_rclk == $past(edge_s))
		else $error("recovered clock not at selected level");

	// Lock with enable high starts the clock within two edges
	run_locked_a: assert property (s_gain ##1 s_kept |=> o_rclk_oe)
		else $error("clock not enabled after lock");

	// Waking from sleep restarts the PLL with lock still high
	wake_reacq_a: assert property (state_q == sro_pkg::SRO_ST_SLEEP && awake_s
		|=> o_lock_n && o_lock_oe && o_pll_run)
		else $error("wake-up did not restart acquisition");

	// Lock gained event matches the indicator going low
	gain_lock_a: assert property (ev[`SRO_EV_LOCK_GAIN] |=> !o_lock_n)
		else $error("lock event without indicator low");

	// Filtered lock is honoured within two cycles
	acquire_bound_a: assert property (lock_wait <= 2'h2)
		else $error("lock not taken in time");
endmodule

/* rtl/sro_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module sro_pin_sync #(
	parameter int         W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] meta;        // First stage, read only by the second
	logic [W-1:0] stage2;      // Second stage
	logic [W-1:0] stage3;      // Third stage
	logic [W-1:0] next_level;  // Filtered level

	// Accept a bit only once stages two and three agree
	always_comb begin
		for (int k = 0; k < W; k++) begin
			next_level[k] = (stage2[k] == stage3[k]) ? stage3[k] : o_level[k];
		end
	end

	// Shift chain and filtered level
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			meta    <= RST_VAL;
			stage2  <= RST_VAL;
			stage3  <= RST_VAL;
			o_level <= RST_VAL;
		end else begin
			meta    <= i_pin;
			stage2  <= meta;
			stage3  <= stage2;
			o_level <= next_level;
		end
	end
endmodule

/* rtl/sro_pkg.sv */
// Types for the serial receiver output control block
package sro_pkg;

	// Link state of the output controller
	typedef enum logic [1:0] {
		SRO_ST_SLEEP   = 2'b00,
		SRO_ST_ACQUIRE = 2'b01,
		SRO_ST_LOCKED  = 2'b10
	} sro_state_t;

endpackage

/* rtl/sro_regs.sv */
// Status, mask and live-state registers with interrupt output
`timescale 1ns/1ps
`include "sro_cfg.svh"

module sro_regs (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	sro_regs_if.regs  bus
);
	logic [`SRO_EV_W-1:0]   status;       // Sticky event bits
	logic [`SRO_EV_W-1:0]   mask;         // Interrupt enables
	logic [`SRO_EV_W-1:0]   clr;          // Write-one-to-clear bits
	logic [`SRO_EV_W-1:0]   next_status;
	logic [`SRO_EV_W-1:0]   next_mask;
	logic                   next_irq;
	logic [`SRO_DATA_W-1:0] next_rdata;
	logic [`SRO_DATA_W-1:0] rdata_q;      // Read data register
	logic                   irq_q;        // Interrupt register

	// Next register values; a new event beats a clear in the same cycle
	always_comb begin
		clr         = (bus.wr && bus.addr == `SRO_REG_STATUS) ? bus.wdata[`SRO_EV_W-1:0] : '0;
		next_status = (status & ~clr) | bus.ev;
		next_mask   = (bus.wr && bus.addr == `SRO_REG_MASK) ? bus.wdata[`SRO_EV_W-1:0] : mask;
		next_irq    = |(next_status & next_mask);
		next_rdata  = '0;
		if (bus.rd) begin
			case (bus.addr)
				`SRO_REG_STATUS: next_rdata = {29'h0, status};
				`SRO_REG_MASK:   next_rdata = {29'h0, mask};
				`SRO_REG_LIVE:   next_rdata = {28'h0, bus.live};
				default:         next_rdata = '0;  // Unmapped reads zero
			endcase
		end
	end

	// Register stage
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			status  <= `SRO_STATUS_RST;
			mask    <= `SRO_MASK_RST;
			irq_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			status  <= next_status;
			mask    <= next_mask;
			irq_q   <= next_irq;
			rdata_q <= next_rdata;
		end
	end

	assign bus.rdata = rdata_q;
	assign bus.irq   = irq_q;

	// Unmasked event raises the interrupt next cycle
	irq_raise_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		|(bus.ev & next_mask) |=> irq_q)
		else $error("unmasked event did not raise interrupt");
	// Event pulse survives a same-cycle clear
	set_wins_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		bus.ev[`SRO_EV_LOCK_LOSS] |=> status[`SRO_EV_LOCK_LOSS])
		else $error("lock loss event lost");
endmodule

/* rtl/sro_regs_if.sv */
// Interface between the output controller and its register file
`timescale 1ns/1ps
`include "sro_cfg.svh"

interface sro_regs_if;
	logic [`SRO_ADDR_W-1:0] addr;   // Bus address
	logic [`SRO_DATA_W-1:0] wdata;  // Bus write data
	logic                   wr;     // Write strobe
	logic                   rd;     // Read strobe
	logic [`SRO_DATA_W-1:0] rdata;  // Registered read data
	logic                   irq;    // Registered interrupt level
	logic [`SRO_EV_W-1:0]   ev;     // One-cycle event pulses
	logic [3:0]             live;   // Live state for reading

	// Controller side
	modport ctrl (output addr, output wdata, output wr, output rd, output ev, output live,
		input rdata, input irq);
	// Register file side
	modport regs (input addr, input wdata, input wr, input rd, input ev, input live,
		output rdata, output irq);
endinterface

/* sim/serial_receiver_output_control_test.sv */
// Self-checking bench for the output and lock control
`timescale 1ns/1ps

module serial_receiver_output_control_test;
	logic        i_mclk, i_rst, lock_req, sleep_n, oe, edge_sel, wr, rd; // Stimulus
	logic [3:0]  addr;                                                 // Bus address
	logic [31:0] wdata, rdata, d;                                      // Bus data
	logic [9:0]  word, dout, w;                                        // Words
	logic        stb, pll_lock, irq, dout_oe, rclk, rclk_oe, lock_n, lock_oe, pll_run;
	int          n_errors, samples_checked, cycles;                    // Counters

	sro_link_model u_sro_link_model (.i_mclk(i_mclk), .i_lock_req(lock_req), .i_pll_run(pll_run),
		.o_pll_lock(pll_lock), .o_word(word), .o_word_stb(stb));

	sro_out_ctrl u_sro_out_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_pll_lock(pll_lock), .i_word(word),
		.i_word_stb(stb), .i_sleep_control_n(sleep_n), .i_out_enable(oe), .i_clk_edge_sel(edge_sel),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
		.o_parallel_data_out(dout), .o_parallel_data_out_oe(dout_oe), .o_rclk(rclk),
		.o_rclk_oe(rclk_oe), .o_lock_n(lock_n), .o_lock_oe(lock_oe), .o_pll_run(pll_run));

	// 40 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle register write
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge i_mclk);
		wr <= 1'b0;
		@(posedge i_mclk);
	endtask

	// One-cycle register read, data taken in the following cycle
	task automatic bus_rd(input logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_mclk);
		rd <= 1'b0;
		@(negedge i_mclk);
		d = rdata;
		@(posedge i_mclk);
	endtask

	// Let pin synchronisers and PLL lock settle, stop mid-cycle
	task automatic settle;
		repeat (12) @(posedge i_mclk);
		@(negedge i_mclk);
	endtask

	// Verdict and end of run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Power-up: unlocked, data and clock floating
	task automatic t_reset;
		@(negedge i_mclk);
		chk(lock_n, 1'b1);
		chk(lock_oe, 1'b1);
		chk({dout_oe, rclk_oe}, 2'h0);
		@(posedge i_mclk);
		$display("test reset done");
	endtask

	// Lock gained, event raised, masked in, cleared
	task automatic t_lock;
		oe <= 1'b1;
		lock_req <= 1'b1;
		settle;
		chk(lock_n, 1'b0);
		chk({dout_oe, rclk_oe}, 2'h3);
		@(posedge i_mclk);
		bus_wr(4'h4, 32'h1);
		bus_rd(4'h0);
		chk(d[0], 1'b1);
		chk(irq, 1'b1);
		bus_wr(4'h0, 32'h1);
		@(negedge i_mclk);
		chk(irq, 1'b0);
		@(posedge i_mclk);
		$display("test lock done");
	endtask

	// Word and clock phase for both edge selections
	task automatic t_edge;
		for (int e = 0; e < 2; e++) begin
			edge_sel <= e[0];
			settle;
			for (int k = 0; k < 6 && stb !== 1'b1; k++) @(negedge i_mclk);
			w = word;
			@(negedge i_mclk);
			chk(dout, w);
			chk(rclk, !e[0]);
			@(negedge i_mclk);
			chk(rclk, e[0]);
			@(posedge i_mclk);
		end
		$display("test edge done");
	endtask

	// Enable low floats data and clock, lock still driven
	task automatic t_oe_low;
		oe <= 1'b0;
		settle;
		chk({dout_oe, rclk_oe}, 2'h0);
		chk({lock_oe, lock_n}, 2'h2);
		@(posedge i_mclk);
		oe <= 1'b1;
		$display("test enable done");
	endtask

	// Sleep floats everything and stops the PLL
	task automatic t_sleep;
		bus_wr(4'h4, 32'h7);
		sleep_n <= 1'b0;
		settle;
		chk({dout_oe, rclk_oe, lock_oe, pll_run}, 4'h0);
		chk(irq, 1'b1);
		@(posedge i_mclk);
		bus_rd(4'h0);
		chk(d[2], 1'b1);
		sleep_n <= 1'b1;
		bus_wr(4'h0, 32'h7);
		$display("test sleep done");
	endtask

	// Lock loss after wake-up, live state and an unmapped read
	task automatic t_loss;
		settle;
		chk(lock_n, 1'b0);
		@(posedge i_mclk);
		lock_req <= 1'b0;
		settle;
		chk(lock_n, 1'b1);
		chk({dout_oe, rclk_oe}, 2'h0);
		@(posedge i_mclk);
		bus_rd(4'h0);
		chk(d[1], 1'b1);
		bus_rd(4'h8);
		chk(d, 32'hc);
		bus_rd(4'hc);
		chk(d, 32'h0);
		$display("test loss done");
	endtask

	// Hang guard
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			give_verdict;
		end
	end

	// Main sequence
	initial begin
		{i_rst, lock_req, sleep_n, oe, edge_sel, wr, rd} = 7'h50;
		addr = 4'h0;
		wdata = 32'h0;
		{n_errors, samples_checked, cycles} = '0;
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		t_reset;
		t_lock;
		t_edge;
		t_oe_low;
		t_sleep;
		t_loss;
		give_verdict;
	end
endmodule

/* sim/sro_link_model.sv */
// Far-side link model: PLL lock source and recovered word stream
`timescale 1ns/1ps

module sro_link_model (
	input  wire logic       i_mclk,
	input  wire logic       i_lock_req,
	input  wire logic       i_pll_run,
	output logic            o_pll_lock,
	output logic [9:0]      o_word,
	output logic            o_word_stb
);
	logic [1:0] gap; // Word spacing counter

	// Idle at time zero, no lock
	initial begin
		gap = 2'h0;
		o_pll_lock = 1'b0;
		o_word = 10'h000;
		o_word_stb = 1'b0;
	end

	// Lock only while sync symbols are sent and the PLL runs off the reference
	always @(posedge i_mclk) begin
		o_pll_lock <= i_lock_req && i_pll_run;
		gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
		o_word_stb <= o_pll_lock && (gap == 2'h2);
		// Word line toggles between strobes, never holds stale data
		o_word <= (gap == 2'h2) ? o_word + 10'h07b : ~o_word;
	end
endmodule
